// [hdl/aesrd_round_datapath.sv]
// Single-cycle cipher round datapath: one operation taken per clock, result registered.
// Assumes the issuing pipeline holds operands valid with i_valid in the same cycle.
//
// Contract
// - 128-bit blocks; 10, 12, 14 rounds.
// - Six operations offered.
// - Decryption uses equivalent inverse cipher.
// - State from register, key register or memory.
// - Word j is column j, row0 low.
// - Byte k at 8k+7..8k; element byte 4j+i.
// - Bit 7 is byte msb, unchanged.
// - Column mixing 02,03,01,01 modulo 11b.
// - Row i rotates left i bytes.
// - Substitution indexed by nibbles, 256 entries.
// - Word rotation outputs bytes 0,3,2,1.
`timescale 1ns/10ps
`include "aesrd_regs.svh"
module aesrd_round_datapath (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Operation request
    input wire logic i_valid,
    input wire aesrd_pkg::aesrd_op_t i_op,
    input wire aesrd_pkg::aesrd_klen_t i_key_len,
    input wire logic i_key_from_mem,
    input wire logic [7:0] i_rcon,
    // Operands
    input wire logic [`AESRD_BLK_W-1:0] i_state,
    input wire logic [`AESRD_BLK_W-1:0] i_key_reg,
    input wire logic [`AESRD_BLK_W-1:0] i_key_mem,
    // Result
    output logic o_valid,
    output logic [`AESRD_BLK_W-1:0] o_result,
    output logic [3:0] o_round_cnt,
    output logic o_seq_err
);
    // ========================================================
    // Field arithmetic
    function automatic logic [7:0] xt(input logic [7:0] b);
        xt = {b[6:0], 1'b0} ^ (b[7] ? `AESRD_GF_POLY : 8'h00);
    endfunction
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] t;
        r = 8'h00;
        t = a;
        for (int n = 0; n < 8; n++) begin
            if (b[n]) begin
                r = r ^ t;
            end
            t = xt(t);
        end
        gmul = r;
    endfunction
    // Inverse as x^254; zero maps to zero as the table requires.
    function automatic logic [7:0] ginv(input logic [7:0] x);
        logic [7:0] r;
        logic [7:0] t;
        r = 8'h01;
        t = x;
        for (int n = 0; n < 7; n++) begin
            t = gmul(t, t);
            r = gmul(r, t);
        end
        ginv = r;
    endfunction
    function automatic logic [7:0] rl(input logic [7:0] b, input int s);
        rl = (b << s) | (b >> (8 - s));
    endfunction
    // Computed rather than tabulated: the full 16x16 tables cost more area in text
    // than the arithmetic, at the price of a deeper combinational path.
    function automatic logic [7:0] sbox(input logic [7:0] b);
        logic [7:0] v;
        v = ginv(b);
        sbox = v ^ rl(v, 1) ^ rl(v, 2) ^ rl(v, 3) ^ rl(v, 4) ^ `AESRD_AFF_C;
    endfunction
    function automatic logic [7:0] isbox(input logic [7:0] b);
        isbox = ginv(rl(b, 1) ^ rl(b, 3) ^ rl(b, 6) ^ `AESRD_IAFF_C);
    endfunction
    // ========================================================
    // Column and state transforms
    function automatic logic [31:0] mixcol(input logic [31:0] c);
        logic [7:0] s0, s1, s2, s3;
        {s3, s2, s1, s0} = c;
        mixcol[7:0] = gmul(8'h02, s0) ^ gmul(8'h03, s1) ^ s2 ^ s3;
        mixcol[15:8] = s0 ^ gmul(8'h02, s1) ^ gmul(8'h03, s2) ^ s3;
        mixcol[23:16] = s0 ^ s1 ^ gmul(8'h02, s2) ^ gmul(8'h03, s3);
        mixcol[31:24] = gmul(8'h03, s0) ^ s1 ^ s2 ^ gmul(8'h02, s3);
    endfunction
    function automatic logic [31:0] imixcol(input logic [31:0] c);
        logic [7:0] s0, s1, s2, s3;
        {s3, s2, s1, s0} = c;
        imixcol[7:0] = gmul(8'h0e, s0) ^ gmul(8'h0b, s1) ^ gmul(8'h0d, s2) ^
                       gmul(8'h09, s3);
        imixcol[15:8] = gmul(8'h09, s0) ^ gmul(8'h0e, s1) ^ gmul(8'h0b, s2) ^ gmul(8'h0d, s3);
        imixcol[23:16] = gmul(8'h0d, s0) ^ gmul(8'h09, s1) ^ gmul(8'h0e, s2) ^ gmul(8'h0b, s3);
        imixcol[31:24] = gmul(8'h0b, s0) ^ gmul(8'h0d, s1) ^ gmul(8'h09, s2) ^ gmul(8'h0e, s3);
    endfunction
    function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
        for (int j = 0; j < 4; j++) begin
            mix[32*j +: 32] = inv ? imixcol(s[32*j +: 32]) : mixcol(s[32*j +: 32]);
        end
    endfunction
    // Element (i,j) is byte 4j+i; row i moves left by i, or right when inverting.
    function automatic logic [127:0] shift(input logic [127:0] s, input logic inv);
        int src;
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 4; i++) begin
                src = inv ? ((j - i + 4) % 4) : ((j + i) % 4);
                shift[8*(4*j+i) +: 8] = s[8*(4*src+i) +: 8];
            end
        end
    endfunction
    function automatic logic [127:0] subst(input logic [127:0] s, input logic inv);
        for (int k = 0; k < 16; k++) begin
            subst[8*k +: 8] = inv ? isbox(s[8*k +: 8]) : sbox(s[8*k +: 8]);
        end
    endfunction
    // Substitution of one key word, cut on purpose from the full-state path.
    function automatic logic [31:0] subw(input logic [31:0] w);
        logic [127:0] t;
        t = subst({96'h0, w}, 1'b0);
        subw = t[31:0];
    endfunction
    function automatic logic [31:0] rotw(input logic [31:0] w);
        rotw = {w[7:0], w[31:8]};
    endfunction

    // ========================================================
    // Operation decode
    wire logic [127:0] key_sel = i_key_from_mem ? i_key_mem : i_key_reg;
    wire logic is_dec = (i_op == aesrd_pkg::AESRD_DEC_ROUND) ||
                        (i_op == aesrd_pkg::AESRD_DEC_FINAL);
    wire logic is_final = (i_op == aesrd_pkg::AESRD_ENC_FINAL) ||
                          (i_op == aesrd_pkg::AESRD_DEC_FINAL);
    wire logic is_round = (i_op == aesrd_pkg::AESRD_ENC_ROUND) ||
                          (i_op == aesrd_pkg::AESRD_DEC_ROUND);
    // Equivalent inverse order: inverse shift, inverse substitution, inverse mix, key.
    wire logic [127:0] sub_out = subst(shift(i_state, is_dec), is_dec);
    wire logic [127:0] mix_out = mix(sub_out, is_dec);
    wire logic [127:0] rnd_res = (is_final ? sub_out : mix_out) ^ key_sel;
    wire logic [31:0] sw1 = subw(i_state[63:32]);
    wire logic [31:0] sw3 = subw(i_state[127:96]);
    wire logic [31:0] rc32 = {24'h0, i_rcon};
    wire logic [127:0] kga_res = {rotw(sw3) ^ rc32, sw3, rotw(sw1) ^ rc32, sw1};
    wire logic [127:0] imc_res = mix(i_state, 1'b1);
    logic [127:0] res_next;
    always_comb begin
        case (i_op)
            aesrd_pkg::AESRD_ENC_ROUND,
            aesrd_pkg::AESRD_ENC_FINAL,
            aesrd_pkg::AESRD_DEC_ROUND,
            aesrd_pkg::AESRD_DEC_FINAL: res_next = rnd_res;
            aesrd_pkg::AESRD_INV_MIX: res_next = imc_res;
            aesrd_pkg::AESRD_KEY_ASSIST: res_next = kga_res;
            default: res_next = `AESRD_RES_RST;
        endcase
    end

    // ========================================================
    // Round sequence tracking: a final round must follow rounds-1 normal rounds.
    // The counter does not tell encryption rounds from decryption rounds, so a
    // mixed sequence of the right length passes without a flag.
    wire logic [3:0] rounds = (i_key_len == aesrd_pkg::AESRD_KEY_256) ? `AESRD_ROUNDS_K256 :
                              (i_key_len == aesrd_pkg::AESRD_KEY_192) ? `AESRD_ROUNDS_K192 :
                              `AESRD_ROUNDS_K128;
    wire logic [3:0] cnt_next = (i_valid && is_final) ? 4'h0 :
                                (i_valid && is_round) ? o_round_cnt + 4'h1 : o_round_cnt;
    wire logic err_next = i_valid && is_final && (o_round_cnt != rounds - 4'h1);

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_valid <= 1'b0;
            o_result <= `AESRD_RES_RST;
            o_round_cnt <= 4'h0;
            o_seq_err <= 1'b0;
        end else begin
            o_valid <= i_valid;
            o_result <= i_valid ? res_next : o_result;
            o_round_cnt <= cnt_next;
            o_seq_err <= err_next;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    a_valid_lat: assert property (i_valid |=> o_valid) else $error("result valid missing");
    a_hold_idle: assert property (!i_valid |=> $stable(o_result)) else $error("result moved");
    a_valid_drop: assert property (!i_valid |=> !o_valid) else $error("stray result valid");
    a_imc_nokey: assert property (i_valid && i_op == aesrd_pkg::AESRD_INV_MIX
        |=> mix(o_result, 1'b0) == $past(i_state)) else $error("inverse mix wrong");
    a_mix_inverse: assert property (mix(mix(i_state, 1'b0), 1'b1) == i_state)
        else $error("mix pair not identity");
    a_shift_inverse: assert property (shift(shift(i_state, 1'b0), 1'b1) == i_state)
        else $error("shift pair not identity");
    a_sbox_inverse: assert property (subst(subst(i_state, 1'b0), 1'b1) == i_state)
        else $error("substitution pair not identity");
    a_sbox_zero: assert property (sbox(8'h00) == `AESRD_AFF_C) else $error("sbox origin");
    a_final_nomix: assert property (i_valid && i_op == aesrd_pkg::AESRD_ENC_FINAL
        |=> o_result == (subst(shift($past(i_state), 1'b0), 1'b0) ^ $past(key_sel)))
        else $error("final round wrong");
    a_key_source: assert property (i_valid && i_op == aesrd_pkg::AESRD_ENC_ROUND && i_key_from_mem
        |=> o_result == (mix(subst(shift($past(i_state), 1'b0), 1'b0), 1'b0) ^ $past(i_key_mem)))
        else $error("memory key not used");
    a_rotw_bytes: assert property (i_valid && i_op == aesrd_pkg::AESRD_KEY_ASSIST
        |=> o_result[31:0] == $past(sw1) && o_result[63:32] == ({$past(sw1[7:0]),
        $past(sw1[31:8])} ^ {24'h0, $past(i_rcon)})) else $error("key assist wrong");
    a_seq_count: assert property (i_valid && is_final && o_round_cnt == rounds - 4'h1
        |=> !o_seq_err && o_round_cnt == 4'h0) else $error("sequence flag wrong");
    a_seq_err_set: assert property (i_valid && is_final && o_round_cnt != rounds - 4'h1
        |=> o_seq_err) else $error("sequence error missing");
    c_enc_round: cover property (i_valid && i_op == aesrd_pkg::AESRD_ENC_ROUND);
    c_dec_final: cover property (i_valid && i_op == aesrd_pkg::AESRD_DEC_FINAL);
    c_full_seq: cover property (i_valid && is_final && o_round_cnt == `AESRD_ROUNDS_K256 - 4'h1);
    c_seq_err: cover property (o_seq_err);
    c_key_assist: cover property (i_valid && i_op == aesrd_pkg::AESRD_KEY_ASSIST);
endmodule // aesrd_round_datapath

// [common/aesrd_regs.svh]
// Constants for the round datapath: widths, round counts and field constants.
// Assumes inclusion by bare name from the datapath and its package users.
`ifndef AESRD_REGS_SVH
`define AESRD_REGS_SVH
`define AESRD_BLK_W 128
`define AESRD_WORD_W 32
`define AESRD_ROUNDS_K128 4'ha
`define AESRD_ROUNDS_K192 4'hc
`define AESRD_ROUNDS_K256 4'he
`define AESRD_GF_POLY 8'h1b
`define AESRD_AFF_C 8'h63
`define AESRD_IAFF_C 8'h05
`define AESRD_OP_RST 3'h0
`define AESRD_RES_RST 128'h0
`endif

// [common/aesrd_pkg.sv]
// Types shared by the round datapath and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package aesrd_pkg;
    typedef enum logic [2:0] {
        AESRD_ENC_ROUND = 3'h0,
        AESRD_ENC_FINAL = 3'h1,
        AESRD_DEC_ROUND = 3'h2,
        AESRD_DEC_FINAL = 3'h3,
        AESRD_INV_MIX = 3'h4,
        AESRD_KEY_ASSIST = 3'h5
    } aesrd_op_t;
    typedef enum logic [1:0] {
        AESRD_KEY_128 = 2'h0,
        AESRD_KEY_192 = 2'h1,
        AESRD_KEY_256 = 2'h2
    } aesrd_klen_t;
endpackage

// [tb/aesrd_key_mem_model.sv]
// Memory-operand side of the issuing pipeline: four 128-bit round keys.
// Assumes the bench loads the words before the first request.
`timescale 1ns/10ps
module aesrd_key_mem_model (
    // Select
    input wire logic i_sel,
    input wire logic [1:0] i_addr,
    // Key word
    output logic [127:0] o_key
);
    logic [127:0] mem [4];
    // An unselected operand shows the inverted word, so a stale value never matches.
    assign o_key = i_sel ? mem[i_addr] : ~mem[i_addr];
endmodule // aesrd_key_mem_model

// [tb/aesrd_round_datapath_tb.sv]
// Self-checking bench for the round datapath, with a reference model.
// Assumes the one-cycle answer and the round counter described for the block.
`timescale 1ns/10ps
module aesrd_round_datapath_tb;
    typedef struct {logic [127:0] r; logic [3:0] c; logic e;} aesrd_exp_t;
    logic i_mclk = 1'b0, i_srst = 1'b1, i_valid = 1'b0, i_key_from_mem = 1'b0, o_valid, o_seq_err;
    aesrd_pkg::aesrd_op_t i_op = aesrd_pkg::AESRD_ENC_ROUND;
    aesrd_pkg::aesrd_klen_t i_key_len = aesrd_pkg::AESRD_KEY_128;
    logic [7:0] i_rcon = 8'h00;
    logic [1:0] addr = 2'h0;
    logic [127:0] i_state = 128'h0, i_key_reg = 128'h0, i_key_mem, o_result, last = 128'h0;
    logic [3:0] o_round_cnt, cnt = 4'h0;
    logic [127:0] fixed_state = 128'h0;
    bit use_fixed = 1'b0;
    logic [7:0] sb [256], isb [256];
    aesrd_exp_t q [$];
    int error_cnt = 0, checks = 0, cyc = 0;
    aesrd_round_datapath dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_valid(i_valid),
        .i_op(i_op), .i_key_len(i_key_len), .i_key_from_mem(i_key_from_mem), .i_rcon(i_rcon),
        .i_state(i_state), .i_key_reg(i_key_reg), .i_key_mem(i_key_mem), .o_valid(o_valid),
        .o_result(o_result), .o_round_cnt(o_round_cnt), .o_seq_err(o_seq_err));
    aesrd_key_mem_model km (.i_sel(i_key_from_mem), .i_addr(addr), .o_key(i_key_mem));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    // ========================================
    // Reference model
    function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
        logic [7:0] p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
        end
        return p;
    endfunction
    function automatic logic [127:0] mix(logic [127:0] s, logic [31:0] c);
        logic [127:0] o = 128'h0;
        for (int n = 0; n < 64; n++) begin
            o[8*(n/4)+:8] ^= gm(c[8*((n%4-n/4%4+4)%4)+:8], s[32*(n/16)+8*(n%4)+:8]);
        end
        return o;
    endfunction
    function automatic logic [127:0] ssb(logic [127:0] s, bit inv);
        logic [127:0] o;
        for (int n = 0; n < 16; n++) begin
            o[8*n+:8] = s[8*(4*((n/4+(inv ? 4-n%4 : n%4))%4)+n%4)+:8];
            o[8*n+:8] = inv ? isb[o[8*n+:8]] : sb[o[8*n+:8]];
        end
        return o;
    endfunction
    function automatic logic [31:0] sw(logic [31:0] w);
        return {sb[w[31:24]], sb[w[23:16]], sb[w[15:8]], sb[w[7:0]]};
    endfunction
    // Printed vectors list the lowest byte first; bit order inside a byte stays.
    function automatic logic [127:0] brev(logic [127:0] v);
        logic [127:0] o;
        for (int n = 0; n < 16; n++) o[8*n+:8] = v[8*(15-n)+:8];
        return o;
    endfunction
    function automatic logic [127:0] model(logic [2:0] op, logic [127:0] s, logic [127:0] k,
                                           logic [7:0] rc);
        logic [31:0] a1 = sw(s[63:32]), a3 = sw(s[127:96]);
        case (op)
            3'h0: return mix(ssb(s, 0), 32'h01010302) ^ k;
            3'h1: return ssb(s, 0) ^ k;
            3'h2: return mix(ssb(s, 1), 32'h090d0b0e) ^ k;
            3'h3: return ssb(s, 1) ^ k;
            3'h4: return mix(s, 32'h090d0b0e);
            3'h5: return {{a3[7:0], a3[31:8]} ^ {24'h0, rc}, a3,
                          {a1[7:0], a1[31:8]} ^ {24'h0, rc}, a1};
            default: return 128'h0;
        endcase
    endfunction
    // ========================================
    // Driver, monitor and report
    task automatic chk(string n, logic [127:0] seen, logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic issue(logic [2:0] op, logic [1:0] kl);
        aesrd_exp_t e;
        logic [127:0] s = {$urandom, $urandom, $urandom, $urandom};
        logic [127:0] kr = {$urandom, $urandom, $urandom, $urandom};
        logic [7:0] rc = 8'($urandom);
        logic m = 1'($urandom);
        logic [1:0] a = 2'($urandom);
        if (use_fixed) s = fixed_state;
        e.r = model(op, s, m ? km.mem[a] : kr, rc);
        e.e = (op == 3'h1 || op == 3'h3) && cnt != 4'(9 + 2 * kl);
        cnt = (op == 3'h1 || op == 3'h3) ? 4'h0 : (op == 3'h0 || op == 3'h2) ? cnt + 4'h1 : cnt;
        e.c = cnt;
        @(posedge i_mclk);
        i_valid <= 1'b1;
        i_op <= aesrd_pkg::aesrd_op_t'(op);
        i_key_len <= aesrd_pkg::aesrd_klen_t'(kl);
        i_key_from_mem <= m;
        addr <= a;
        i_rcon <= rc;
        i_state <= s;
        i_key_reg <= kr;
        q.push_back(e);
    endtask
    task automatic idle();
        @(posedge i_mclk);
        i_valid <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    always @(posedge i_mclk) begin
        aesrd_exp_t e;
        #1;
        if (!i_srst && o_valid === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            chk("result", o_result, e.r);
            chk("round count", 128'(o_round_cnt), 128'(e.c));
            chk("sequence error", 128'(o_seq_err), 128'(e.e));
            last = o_result;
        end else if (!i_srst) begin
            chk("held result", o_result, last);
            chk("idle flags", {o_seq_err, o_valid}, 128'h0);
        end
    end
    // ========================================
    // Tests
    initial begin
        void'($urandom(91433));
        for (int n = 0; n < 4; n++) km.mem[n] = {$urandom, $urandom, $urandom, $urandom};
        for (int x = 0; x < 256; x++) begin
            logic [7:0] v = 8'h00;
            for (int y = 1; y < 256; y++) if (gm(8'(x), 8'(y)) == 8'h01) v = 8'(y);
            v = v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]} ^ {v[3:0], v[7:4]} ^ 8'h63;
            sb[x] = v;
            isb[v] = 8'(x);
        end
        repeat (3) @(posedge i_mclk);
        i_srst <= 1'b0;
        chk("table entry", 128'(sb[8'h53]), 128'hed);
        for (int k = 0; k < 3; k++) begin
            repeat (9 + 2 * k) issue(3'h0, 2'(k));
            issue(3'h1, 2'(k));
            repeat (9 + 2 * k) issue(3'h2, 2'(k));
            issue(3'h3, 2'(k));
        end
        $display("test full sequences done");
        repeat (3) issue(3'h0, 2'h0);
        issue(3'h3, 2'h0);
        issue(3'h1, 2'h2);
        idle();
        $display("test short sequences done");
        fixed_state = brev(128'hd4bf5d30e0b452aeb84111f11e2798e5);
        chk("reversed vector", fixed_state, 128'he598271ef11141b8ae52b4e0305dbfd4);
        chk("matrix element", 128'(fixed_state[39:32]), 128'he0);
        use_fixed = 1'b1;
        for (int op = 0; op < 8; op++) issue(3'(op), 2'h0);
        use_fixed = 1'b0;
        idle();
        $display("test published layout done");
        repeat (300) begin
            issue(3'($urandom % 6), 2'($urandom % 3));
            if ($urandom % 3 == 0) idle();
        end
        idle();
        repeat (3) @(posedge i_mclk);
        chk("pending results", 128'(q.size()), 128'h0);
        $display("test random operations done");
        i_srst <= 1'b1;
        @(posedge i_mclk);
        @(posedge i_mclk);
        i_srst <= 1'b0;
        cnt = 4'h0;
        last = 128'h0;
        repeat (9) issue(3'h2, 2'h0);
        issue(3'h3, 2'h0);
        idle();
        repeat (3) @(posedge i_mclk);
        chk("pending after reset", 128'(q.size()), 128'h0);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule // aesrd_round_datapath_tb
